/* File: grpc_params.svh */
// Offsets, field positions, reset values and counts for the pin block
`ifndef GRPC_PARAMS_SVH
`define GRPC_PARAMS_SVH

`define GRPC_NUM_PINS      13
`define GRPC_IDX_W         8

// Pin block register indices, byte address is four times the index
`define GRPC_IDX_CFG_FIRST 8'h00
`define GRPC_IDX_CFG_LAST  8'h0c
`define GRPC_IDX_DAT1      8'h15
`define GRPC_IDX_DAT2      8'h16
`define GRPC_BLOCK_SPAN    8'h20

// Own control, status and mask registers, outside the pin block
`define GRPC_IDX_OWN_LO    8'h80
`define GRPC_IDX_CTRL      8'h80
`define GRPC_IDX_BASE      8'h81
`define GRPC_IDX_STS       8'h82
`define GRPC_IDX_MSK       8'h83

// Configuration byte fields
`define GRPC_BIT_DIR       0
`define GRPC_BIT_POL       1
`define GRPC_BIT_FSEL      2
`define GRPC_BIT_FSEL_HI   3
`define GRPC_BIT_OTYPE     7
`define GRPC_FN_MON        2'h1
`define GRPC_FN_EDGE       2'h2

// Pin numbers within the thirteen-pin vector
`define GRPC_PIN_1_6       6
`define GRPC_PIN_1_7       7
`define GRPC_PIN_2_0       8
`define GRPC_PIN_2_1       9
`define GRPC_PIN_2_2       10
`define GRPC_PIN_2_3       11
`define GRPC_GRP1_PINS     8
`define GRPC_GRP2_PINS     5

// Reset values on standby power-on reset
`define GRPC_RST_CFG1      8'h01
`define GRPC_RST_CFG2      8'h04
`define GRPC_RST_CFG24     8'h05

// Status and mask bits
`define GRPC_STS_W         3
`define GRPC_STS_WAKE      0
`define GRPC_STS_MISC_21   1
`define GRPC_STS_MISC_22   2

`endif

/* File: grpc_pkg.sv */
// Types shared by the pin block
`include "grpc_params.svh"

package grpc_pkg;

	typedef struct packed {
		logic [`GRPC_NUM_PINS-1:0] out;
		logic [`GRPC_NUM_PINS-1:0] oe;
	} grpc_pad_t;

	typedef struct packed {
		logic [`GRPC_NUM_PINS-1:0][7:0] cfg;
		logic [7:0]                     dat1;
		logic [`GRPC_GRP2_PINS-1:0]     dat2;
		logic                           bank;
		logic [7:0]                     base;
		logic [`GRPC_STS_W-1:0]         sts;
		logic [`GRPC_STS_W-1:0]         msk;
		logic                           irq;
		logic                           ack;
		logic [31:0]                    rdat;
		grpc_pad_t                      pad;
		logic [`GRPC_NUM_PINS-1:0]      sync1;
		logic [`GRPC_NUM_PINS-1:0]      sync2;
		logic [1:0]                     prev;
		logic [1:0]                     tach;
		logic [3:0]                     mon;
	} grpc_state_t;

endpackage

/* File: grpc_pin_cell.sv */
// One pin: direction, polarity and driver type decode
`include "grpc_params.svh"

module grpc_pin_cell (
	// Settings
	input  wire logic [7:0] cfg_i,
	input  wire logic       dat_i,
	input  wire logic       mon_sel_i,
	input  wire logic       force_in_i,
	input  wire logic       mon_low_i,
	// Pad side
	input  wire logic       pin_i,
	output logic            out_o,
	output logic            oe_o,
	output logic            rd_o
);
	logic is_in;
	logic pol;
	logic lvl;

	assign is_in = cfg_i[`GRPC_BIT_DIR] | force_in_i;
	assign pol   = cfg_i[`GRPC_BIT_POL];
	assign lvl   = dat_i ^ pol;

	always_comb begin
		out_o = 1'b0;
		oe_o  = 1'b0;
		rd_o  = dat_i;
		if (mon_sel_i) begin
			// Monitor pins are open drain, settings ignored
			oe_o = mon_low_i;
			rd_o = pin_i;
		end else if (is_in) begin
			rd_o = pin_i ^ pol;
		end else if (cfg_i[`GRPC_BIT_OTYPE]) begin
			oe_o = ~lvl;
		end else begin
			out_o = lvl;
			oe_o  = 1'b1;
		end
	end

endmodule

/* File: grpc_top.sv */
// Runtime pin configuration and data registers for thirteen I/O pins
// Operation
// - Decode only while bank select bit clear
// - Registers sit at offset from programmed base
// - Bit 0 one input, zero output
// - Bit 1 one inverts pin value
// - Bit 7 one open drain, zero push-pull
// - Pin 1.6 bit 2 routes fan input A
// - Pin 1.7 bit 2 routes fan input B
// - Pin 2.0 bit 2 selects high monitor data
// - Pin 2.1 field: GPIO, monitor clock, edge
// - Pin 2.2 field: GPIO, monitor data, edge
// - Pin 2.3 bit 2 selects low monitor clock
// - Group one configs reset to 0x01
// - Unused offsets read zero, ignore writes
// - Reserved configuration bits have no function
// - Data registers map one pin per bit
// - Monitor functions ignore direction, polarity, type
// - Either edge sets wake and misc status
//
// Register access over Wishbone is this design's own decision.
`include "grpc_params.svh"

module grpc_top (
	// Clock, reset, enable
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	// Wishbone slave
	input  wire logic                       cyc_i,
	input  wire logic                       stb_i,
	input  wire logic                       we_i,
	input  wire logic [9:0]                 adr_i,
	input  wire logic [3:0]                 sel_i,
	input  wire logic [31:0]                dat_i,
	output logic      [31:0]                dat_o,
	output logic                            ack_o,
	// Pads
	input  wire logic [`GRPC_NUM_PINS-1:0]  pin_i,
	output grpc_pkg::grpc_pad_t             pad_o,
	// Alternate functions
	output logic      [1:0]                 fan_speed_o,
	input  wire logic [3:0]                 mon_drive_low_i,
	output logic      [3:0]                 mon_level_o,
	// Interrupt
	output logic                            irq_o
);
	import grpc_pkg::*;

	localparam grpc_state_t RST_STATE = '{
		cfg: {`GRPC_RST_CFG24, {4{`GRPC_RST_CFG2}},
			{8{`GRPC_RST_CFG1}}},
		default: '0
	};

	grpc_state_t q;
	grpc_state_t nxt;

	logic [7:0]                idx;
	logic [7:0]                off;
	logic                      req;
	logic                      blk_hit;
	logic [1:0]                fn21;
	logic [1:0]                fn22;
	logic [`GRPC_NUM_PINS-1:0] mon_sel;
	logic [`GRPC_NUM_PINS-1:0] force_in;
	logic [`GRPC_NUM_PINS-1:0] mon_low;
	logic [`GRPC_NUM_PINS-1:0] dat_all;
	logic [`GRPC_NUM_PINS-1:0] cell_out;
	logic [`GRPC_NUM_PINS-1:0] cell_oe;
	logic [`GRPC_NUM_PINS-1:0] cell_rd;
	logic                      edge21;
	logic                      edge22;
	logic [`GRPC_STS_W-1:0]    sts_set;
	logic [`GRPC_STS_W-1:0]    sts_clr;

	assign idx = adr_i[9:2];
	assign off = idx - q.base;
	assign req = cyc_i & stb_i & ~q.ack;
	// Own registers win over a base that overlaps them
	assign blk_hit = ~q.bank & (idx < `GRPC_IDX_OWN_LO) &
		(idx >= q.base) & (off < `GRPC_BLOCK_SPAN);

	assign fn21 = q.cfg[`GRPC_PIN_2_1][`GRPC_BIT_FSEL_HI:`GRPC_BIT_FSEL];
	assign fn22 = q.cfg[`GRPC_PIN_2_2][`GRPC_BIT_FSEL_HI:`GRPC_BIT_FSEL];
	assign dat_all = {q.dat2, q.dat1};

	// Function select decode; code 11 falls back to plain GPIO
	always_comb begin
		mon_sel  = '0;
		force_in = '0;
		mon_low  = '0;
		mon_sel[`GRPC_PIN_2_0]  = q.cfg[`GRPC_PIN_2_0][`GRPC_BIT_FSEL];
		mon_sel[`GRPC_PIN_2_1]  = (fn21 == `GRPC_FN_MON);
		mon_sel[`GRPC_PIN_2_2]  = (fn22 == `GRPC_FN_MON);
		mon_sel[`GRPC_PIN_2_3]  = q.cfg[`GRPC_PIN_2_3][`GRPC_BIT_FSEL];
		force_in[`GRPC_PIN_1_6] = q.cfg[`GRPC_PIN_1_6][`GRPC_BIT_FSEL];
		force_in[`GRPC_PIN_1_7] = q.cfg[`GRPC_PIN_1_7][`GRPC_BIT_FSEL];
		force_in[`GRPC_PIN_2_1] = (fn21 == `GRPC_FN_EDGE);
		force_in[`GRPC_PIN_2_2] = (fn22 == `GRPC_FN_EDGE);
		mon_low[`GRPC_PIN_2_3:`GRPC_PIN_2_0] = mon_drive_low_i;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `GRPC_NUM_PINS; gi++) begin : g_pin
			grpc_pin_cell u_cell (
				.cfg_i      (q.cfg[gi]),
				.dat_i      (dat_all[gi]),
				.mon_sel_i  (mon_sel[gi]),
				.force_in_i (force_in[gi]),
				.mon_low_i  (mon_low[gi]),
				.pin_i      (q.sync2[gi]),
				.out_o      (cell_out[gi]),
				.oe_o       (cell_oe[gi]),
				.rd_o       (cell_rd[gi])
			);
		end
	endgenerate

	// Either-edge inputs; prev tracks always so a fresh select sees no edge
	assign edge21 = (fn21 == `GRPC_FN_EDGE) &
		(q.sync2[`GRPC_PIN_2_1] ^ q.prev[0]);
	assign edge22 = (fn22 == `GRPC_FN_EDGE) &
		(q.sync2[`GRPC_PIN_2_2] ^ q.prev[1]);

	always_comb begin
		sts_set = '0;
		sts_set[`GRPC_STS_WAKE]    = edge21 | edge22;
		sts_set[`GRPC_STS_MISC_21] = edge21;
		sts_set[`GRPC_STS_MISC_22] = edge22;
		sts_clr = '0;
		if (req & we_i & sel_i[0] & (idx == `GRPC_IDX_STS)) begin
			sts_clr = dat_i[`GRPC_STS_W-1:0];
		end
	end

	always_comb begin
		nxt = q;
		// Pads pass two flops before any logic looks at them
		nxt.sync1 = pin_i;
		nxt.sync2 = q.sync1;
		nxt.prev  = {q.sync2[`GRPC_PIN_2_2], q.sync2[`GRPC_PIN_2_1]};
		nxt.pad.out = cell_out;
		nxt.pad.oe  = cell_oe;
		nxt.tach = {q.sync2[`GRPC_PIN_1_7] & force_in[`GRPC_PIN_1_7],
			q.sync2[`GRPC_PIN_1_6] & force_in[`GRPC_PIN_1_6]};
		nxt.mon = q.sync2[`GRPC_PIN_2_3:`GRPC_PIN_2_0];
		// Set wins over a clear in the same cycle
		nxt.sts = (q.sts & ~sts_clr) | sts_set;
		nxt.ack  = req;
		nxt.rdat = '0;
		if (req & ~we_i) begin
			if (idx == `GRPC_IDX_CTRL) begin
				nxt.rdat[0] = q.bank;
			end else if (idx == `GRPC_IDX_BASE) begin
				nxt.rdat[7:0] = q.base;
			end else if (idx == `GRPC_IDX_STS) begin
				nxt.rdat[`GRPC_STS_W-1:0] = q.sts;
			end else if (idx == `GRPC_IDX_MSK) begin
				nxt.rdat[`GRPC_STS_W-1:0] = q.msk;
			end else if (blk_hit) begin
				if (off <= `GRPC_IDX_CFG_LAST) begin
					// Reserved bits read back as stored
					nxt.rdat[7:0] = q.cfg[off[3:0]];
				end else if (off == `GRPC_IDX_DAT1) begin
					nxt.rdat[7:0] = cell_rd[7:0];
				end else if (off == `GRPC_IDX_DAT2) begin
					nxt.rdat[4:0] = cell_rd[`GRPC_PIN_2_3+1:`GRPC_PIN_2_0];
				end
				// Gaps fall through as zero
			end
		end
		if (req & we_i & sel_i[0]) begin
			if (idx == `GRPC_IDX_CTRL) begin
				nxt.bank = dat_i[0];
			end else if (idx == `GRPC_IDX_BASE) begin
				nxt.base = dat_i[7:0];
			end else if (idx == `GRPC_IDX_MSK) begin
				nxt.msk = dat_i[`GRPC_STS_W-1:0];
			end else if (blk_hit) begin
				if (off <= `GRPC_IDX_CFG_LAST) begin
					nxt.cfg[off[3:0]] = dat_i[7:0];
				end else if (off == `GRPC_IDX_DAT1) begin
					nxt.dat1 = dat_i[7:0];
				end else if (off == `GRPC_IDX_DAT2) begin
					nxt.dat2 = dat_i[`GRPC_GRP2_PINS-1:0];
				end
				// Writes to gaps are dropped
			end
		end
		nxt.irq = |(nxt.sts & nxt.msk);
	end

	// Standby power-on reset is the only reset this block sees
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= RST_STATE;
		end else if (ce_i) begin
			q <= nxt;
		end
	end

	assign dat_o       = q.rdat;
	assign ack_o       = q.ack;
	assign pad_o       = q.pad;
	assign fan_speed_o = q.tach;
	assign mon_level_o = q.mon;
	assign irq_o       = q.irq;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_rd_req;
		ce_i && req && !we_i;
	endsequence

	sequence s_ack_zero;
		ack_o && (dat_o == 32'h0000_0000);
	endsequence

	sequence s_edge21;
		ce_i && edge21;
	endsequence

	sequence s_wr_req;
		ce_i && req && we_i;
	endsequence

	bank_hides_a: assert property (
		s_rd_req ##0 (q.bank && idx < `GRPC_IDX_OWN_LO) |=> s_ack_zero)
		else $error("pin block answered while bank select set");

	base_offset_a: assert property (
		s_rd_req ##0 (blk_hit && off == 8'h00)
		|=> ack_o && dat_o[7:0] == $past(q.cfg[0]))
		else $error("config read at base offset wrong");

	dir_input_a: assert property (
		ce_i && q.cfg[0][`GRPC_BIT_DIR] |=> !pad_o.oe[0])
		else $error("input pin is driven");

	pol_drive_a: assert property (
		ce_i && !q.cfg[0][`GRPC_BIT_DIR] && !q.cfg[0][`GRPC_BIT_OTYPE]
		|=> pad_o.oe[0] &&
			pad_o.out[0] == $past(q.dat1[0] ^ q.cfg[0][`GRPC_BIT_POL]))
		else $error("push-pull level or polarity wrong");

	open_drain_a: assert property (
		ce_i && !q.cfg[1][`GRPC_BIT_DIR] && q.cfg[1][`GRPC_BIT_OTYPE]
		|=> !pad_o.out[1] &&
			pad_o.oe[1] == !$past(q.dat1[1] ^ q.cfg[1][`GRPC_BIT_POL]))
		else $error("open-drain drive wrong");

	fan_route_a: assert property (
		ce_i && q.cfg[`GRPC_PIN_1_6][`GRPC_BIT_FSEL]
		|=> fan_speed_o[0] == $past(q.sync2[`GRPC_PIN_1_6]) &&
			!pad_o.oe[`GRPC_PIN_1_6])
		else $error("fan input A not routed");

	mon_clock_a: assert property (
		ce_i && fn21 == `GRPC_FN_MON
		|=> pad_o.oe[`GRPC_PIN_2_1] == $past(mon_drive_low_i[1]) &&
			!pad_o.out[`GRPC_PIN_2_1])
		else $error("monitor clock pin drive wrong");

	cfg_reset_a: assert property (
		$fell(rst_i) |-> q.cfg[0] == `GRPC_RST_CFG1 &&
			q.cfg[7] == `GRPC_RST_CFG1 && q.cfg[12] == `GRPC_RST_CFG24)
		else $error("configuration reset value wrong");

	gap_zero_a: assert property (
		s_rd_req ##0 (blk_hit && off > `GRPC_IDX_CFG_LAST &&
			off < `GRPC_IDX_DAT1) |=> s_ack_zero)
		else $error("unused offset read not zero");

	edge_status_a: assert property (
		s_edge21 |=> q.sts[`GRPC_STS_WAKE] && q.sts[`GRPC_STS_MISC_21])
		else $error("edge did not set status");

	irq_level_a: assert property (
		ce_i && |(nxt.sts & nxt.msk) |=> irq_o ##1 (irq_o || !ce_i ||
			$past(sts_clr != '0) || $past(req && we_i)))
		else $error("interrupt not raised");

	// Hidden writes must leave every pin register alone
	bank_write_a: assert property (
		s_wr_req ##0 (q.bank && idx < `GRPC_IDX_OWN_LO)
		|=> $stable(q.cfg) && $stable(q.dat1) && $stable(q.dat2))
		else $error("pin register written while bank select set");

	fan_idle_a: assert property (
		ce_i && !q.cfg[`GRPC_PIN_1_6][`GRPC_BIT_FSEL]
		|=> !fan_speed_o[0])
		else $error("fan input A active while plain GPIO");

	fan_route_b_a: assert property (
		ce_i && q.cfg[`GRPC_PIN_1_7][`GRPC_BIT_FSEL]
		|=> fan_speed_o[1] == $past(q.sync2[`GRPC_PIN_1_7]) &&
			!pad_o.oe[`GRPC_PIN_1_7])
		else $error("fan input B not routed");

	mon_data_a: assert property (
		ce_i && q.cfg[`GRPC_PIN_2_0][`GRPC_BIT_FSEL]
		|=> pad_o.oe[`GRPC_PIN_2_0] == $past(mon_drive_low_i[0]) &&
			!pad_o.out[`GRPC_PIN_2_0])
		else $error("high side monitor data drive wrong");

	mon_low_data_a: assert property (
		ce_i && fn22 == `GRPC_FN_MON
		|=> pad_o.oe[`GRPC_PIN_2_2] == $past(mon_drive_low_i[2]) &&
			!pad_o.out[`GRPC_PIN_2_2])
		else $error("low side monitor data drive wrong");

	// Edge input must never drive its own pad
	edge_input_a: assert property (
		ce_i && fn22 == `GRPC_FN_EDGE |=> !pad_o.oe[`GRPC_PIN_2_2])
		else $error("edge input pin is driven");

	mon_low_clock_a: assert property (
		ce_i && q.cfg[`GRPC_PIN_2_3][`GRPC_BIT_FSEL]
		|=> pad_o.oe[`GRPC_PIN_2_3] == $past(mon_drive_low_i[3]) &&
			!pad_o.out[`GRPC_PIN_2_3])
		else $error("low side monitor clock drive wrong");

	in_read_a: assert property (
		s_rd_req ##0 (blk_hit && off == `GRPC_IDX_DAT1 &&
			q.cfg[1][`GRPC_BIT_DIR])
		|=> dat_o[1] == $past(q.sync2[1] ^ q.cfg[1][`GRPC_BIT_POL]))
		else $error("input read level or polarity wrong");

	// A held strobe must not stretch the acknowledge
	ack_pulse_a: assert property (
		ce_i && ack_o |=> !ack_o)
		else $error("acknowledge longer than one cycle");

endmodule

/* File: grpc_top_bench.sv */
// Self-checking bench for the runtime pin configuration block
module grpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import grpc_pkg::*;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [9:0]  adr_i = 10'h000;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic [12:0] pin_i = 13'h0000;
	grpc_pad_t   pad_o;
	logic [1:0]  fan_speed_o;
	logic [3:0]  mon_drive_low_i = 4'h0;
	logic [3:0]  mon_level_o;
	logic        irq_o;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	logic [7:0]  rd;

	always #5 clk_i = ~clk_i;

	grpc_top i_grpc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.pin_i(pin_i), .pad_o(pad_o), .fan_speed_o(fan_speed_o),
		.mon_drive_low_i(mon_drive_low_i), .mon_level_o(mon_level_o),
		.irq_o(irq_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	// Classic cycle; the master never assumes a latency
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] wd);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		sel_i <= 4'hf;
		dat_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			n_mismatch++;
			$display("ERROR %0t no acknowledge", $time);
		end
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		bus(1'b1, idx, v);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk({8'h00, rd}, {8'h00, exp});
	endtask

	task automatic t_reset();
		for (int i = 0; i < 13; i++)
			rdc(8'(i), i < 8 ? 8'h01 : (i < 12 ? 8'h04 : 8'h05));
		rdc(8'h15, 8'h00);
		rdc(8'h16, 8'h00);
	endtask

	task automatic t_unused();
		logic [7:0] gap [4];
		gap = '{8'h0d, 8'h14, 8'h17, 8'h1f};
		foreach (gap[i]) begin
			wr(gap[i], 8'hff);
			rdc(gap[i], 8'h00);
		end
		wr(8'h03, 8'h7d);
		rdc(8'h03, 8'h7d);
		chk(pad_o.oe[3], 1'b0);
		wr(8'h03, 8'h01);
	endtask

	// Pin 1.0 as output: push-pull, inverted, open drain
	task automatic t_drive();
		wr(8'h15, 8'h01);
		wr(8'h00, 8'h00);
		tick(2);
		chk({pad_o.oe[0], pad_o.out[0]}, 2'b11);
		rdc(8'h15, 8'h01);
		wr(8'h00, 8'h02);
		tick(2);
		chk({pad_o.oe[0], pad_o.out[0]}, 2'b10);
		wr(8'h00, 8'h80);
		tick(2);
		chk(pad_o.oe[0], 1'b0);
		wr(8'h15, 8'h00);
		tick(2);
		chk({pad_o.oe[0], pad_o.out[0]}, 2'b10);
		wr(8'h00, 8'h01);
	endtask

	task automatic t_input();
		pin_i[1] <= 1'b1;
		tick(4);
		rdc(8'h15, 8'h02);
		wr(8'h01, 8'h03);
		rdc(8'h15, 8'h00);
		wr(8'h01, 8'h01);
		pin_i[1] <= 1'b0;
	endtask

	task automatic t_fan();
		for (int k = 0; k < 2; k++) begin
			wr(8'(6 + k), 8'h05);
			pin_i[6 + k] <= 1'b1;
			tick(4);
			chk(fan_speed_o[k], 1'b1);
			wr(8'(6 + k), 8'h01);
			tick(2);
			chk(fan_speed_o[k], 1'b0);
			pin_i[6 + k] <= 1'b0;
		end
	endtask

	// Pins 2.0 to 2.3 reset into their monitor function, dir bit zero
	task automatic t_mon();
		wr(8'h16, 8'h0f);
		for (int k = 0; k < 4; k++) begin
			chk(pad_o.oe[8 + k], 1'b0);
			mon_drive_low_i[k] <= 1'b1;
			pin_i[8 + k] <= 1'b1;
			tick(4);
			chk({pad_o.oe[8 + k], pad_o.out[8 + k]}, 2'b10);
			chk(mon_level_o[k], 1'b1);
			mon_drive_low_i[k] <= 1'b0;
			pin_i[8 + k] <= 1'b0;
			tick(2);
		end
		// Codes 00 and 11 both leave pin 2.1 a plain output
		wr(8'h09, 8'h00);
		tick(2);
		chk({pad_o.oe[9], pad_o.out[9]}, 2'b11);
		wr(8'h09, 8'h0c);
		tick(2);
		chk({pad_o.oe[9], pad_o.out[9]}, 2'b11);
		wr(8'h09, 8'h04);
		wr(8'h16, 8'h00);
	endtask

	task automatic t_edge();
		logic [7:0] sts;
		for (int k = 0; k < 2; k++) begin
			sts = 8'h01 | (8'h02 << k);
			wr(8'(9 + k), 8'h09);
			wr(8'h83, 8'h07);
			pin_i[9 + k] <= 1'b1;
			tick(5);
			rdc(8'h82, sts);
			chk(irq_o, 1'b1);
			wr(8'h82, 8'h07);
			rdc(8'h82, 8'h00);
			chk(irq_o, 1'b0);
			wr(8'h83, 8'h00);
			pin_i[9 + k] <= 1'b0;
			tick(5);
			rdc(8'h82, sts);
			chk(irq_o, 1'b0);
			wr(8'h82, 8'h07);
			wr(8'(9 + k), 8'h04);
		end
	endtask

	task automatic t_map();
		wr(8'h00, 8'h55);
		wr(8'h80, 8'h01);
		rdc(8'h00, 8'h00);
		wr(8'h00, 8'haa);
		wr(8'h80, 8'h00);
		rdc(8'h00, 8'h55);
		wr(8'h81, 8'h40);
		rdc(8'h40, 8'h55);
		rdc(8'h00, 8'h00);
		wr(8'h81, 8'h00);
	endtask

	// Low enable freezes the pad synchronisers as well
	task automatic t_freeze();
		ce_i <= 1'b0;
		pin_i[8] <= 1'b1;
		tick(4);
		chk(mon_level_o[0], 1'b0);
		ce_i <= 1'b1;
		tick(4);
		chk(mon_level_o[0], 1'b1);
		pin_i[8] <= 1'b0;
		tick(4);
	endtask

	// Second reset in mid-run restores reset configuration over written values
	task automatic t_rerst();
		wr(8'h00, 8'h82);
		wr(8'h07, 8'h85);
		rst_i <= 1'b1;
		tick(1);
		rst_i <= 1'b0;
		rdc(8'h00, 8'h01);
		rdc(8'h07, 8'h01);
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_unused();
		t_drive();
		t_input();
		t_fan();
		t_mon();
		t_edge();
		t_map();
		t_freeze();
		t_rerst();
		wrap_up();
	end
endmodule
